// file: rtl/lcd_segment_driver_control.v
// control, pixel store, clock chain and common sequencer of a 33x4 segment lcd driver
// assumes an apb master on pclk and the two slow clock sources arriving as asynchronous pins
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "lcd_segment_driver_defines.vh"

// Notes on behaviour
// - driver_on high runs the whole driver; low holds it disabled.
// - in sleep, sleep_run_disable high stops the driver; low keeps it running.
// - pixel write while write_allow low sets write_fault_flag until software clears it.
// - clock_source_sel 1x internal rc, 01 timer1 oscillator, 00 system clock.
// - common_count_sel picks one to four commons, 33 to 132 pixels.
// - waveform_kind 1 inverts phase at frame edges; 0 inverts within each common.
// - half_third_bias_sel picks 1/2 or 1/3 bias for two or three commons only.
// - driver_active_flag reads 1 while the driver runs.
// - write_allow reads 1 while pixel registers may be written.
// - frame_divider code k divides the baseline by k+1.
// - segment enable bit 1 makes the pin a segment driver, disabling its io.
// - segment enable register k covers segments 8k..8k+7; the fifth holds only segment 32.
// - pixel index x for common y covers segments 8(x-6y)..+7; 5, 11, 17 absent.
// - pixel registers holding segment 32 implement only bit 0.
// - post-divider divides the source by 32 or 8192 for a ~1 kHz baseline.
// - common count sets the ring counter length that walks the common lines.
// - control bit 4 reads zero; writable control and phase bits reset to zero.
// - system clock source uses the POSTDIV_SYSTEM post-divider, divide-by-8192 unless the parameter is overridden.
module lcd_segment_driver_control #(
  parameter POSTDIV_SYSTEM = `POSTDIV_SYSTEM
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire internal_rc_31k,
  input wire timer1_osc_clock,
  input wire sleep_mode,
  output reg [3:0] backplane_line,
  output reg [32:0] frontplane_line,
  output reg [32:0] glyph_pin_on,
  output reg phase_invert,
  output reg half_bias_out,
  output reg driver_active_flag
);

////////////////////////////////////////////////////////////////////////////////
// registers
reg [7:0] ctl_ff;
reg [7:0] phs_ff;
reg [7:0] seg_ff [0:4];
reg [7:0] pix_ff [0:`PIX_ENTRIES-1];
reg write_allow_ff;
reg active_ff;

wire [1:0] clock_source_sel = ctl_ff[`CTL_CLOCK_SRC_HI:`CTL_CLOCK_SRC_LO];
wire [1:0] common_count_sel = ctl_ff[`CTL_COMMON_HI:`CTL_COMMON_LO];
wire [3:0] frame_divider = phs_ff[`PHS_DIV_HI:`PHS_DIV_LO];
wire waveform_kind = phs_ff[`PHS_WAVEFORM_KIND];

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers: a change counts once stages two and three agree
reg [2:0] rc_sync_ff;
reg [2:0] t1_sync_ff;
reg [2:0] slp_sync_ff;
reg rc_lvl_ff;
reg t1_lvl_ff;
reg slp_lvl_ff;
wire rc_rise = (rc_sync_ff[1] == rc_sync_ff[2]) && rc_sync_ff[2] && !rc_lvl_ff;
wire t1_rise = (t1_sync_ff[1] == t1_sync_ff[2]) && t1_sync_ff[2] && !t1_lvl_ff;

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    rc_sync_ff <= 3'h0;
    t1_sync_ff <= 3'h0;
    slp_sync_ff <= 3'h0;
    rc_lvl_ff <= 1'b0;
    t1_lvl_ff <= 1'b0;
    slp_lvl_ff <= 1'b0;
  end else begin
    rc_sync_ff <= {rc_sync_ff[1:0], internal_rc_31k};
    t1_sync_ff <= {t1_sync_ff[1:0], timer1_osc_clock};
    slp_sync_ff <= {slp_sync_ff[1:0], sleep_mode};
    if (rc_sync_ff[1] == rc_sync_ff[2]) begin
      rc_lvl_ff <= rc_sync_ff[2];
    end
    if (t1_sync_ff[1] == t1_sync_ff[2]) begin
      t1_lvl_ff <= t1_sync_ff[2];
    end
    if (slp_sync_ff[1] == slp_sync_ff[2]) begin
      slp_lvl_ff <= slp_sync_ff[2];
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// clock chain: source select, post-divider, frame prescaler
reg [12:0] post_cnt_ff;
reg [3:0] pre_cnt_ff;
reg src_tick;
reg [12:0] post_last;

always @* begin
  if (clock_source_sel[1]) begin
    src_tick = rc_rise;
    post_last = `POSTDIV_SLOW - 13'h0001;
  end else if (clock_source_sel == `SRC_TIMER1) begin
    src_tick = t1_rise;
    post_last = `POSTDIV_SLOW - 13'h0001;
  end else begin
    src_tick = 1'b1;
    post_last = POSTDIV_SYSTEM[12:0] - 13'h0001;
  end
end

wire base_tick = active_ff && src_tick && (post_cnt_ff == post_last);
wire step_tick = base_tick && (pre_cnt_ff == frame_divider);

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    post_cnt_ff <= 13'h0000;
    pre_cnt_ff <= 4'h0;
  end else if (!active_ff) begin
    post_cnt_ff <= 13'h0000;
    pre_cnt_ff <= 4'h0;
  end else begin
    if (src_tick) begin
      post_cnt_ff <= (post_cnt_ff >= post_last) ? 13'h0000 : post_cnt_ff + 13'h0001;
    end
    if (base_tick) begin
      pre_cnt_ff <= (pre_cnt_ff == frame_divider) ? 4'h0 : pre_cnt_ff + 4'h1;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// activity and common ring counter
wire nxt_active = ctl_ff[`CTL_DRIVER_ON] && !(slp_lvl_ff && ctl_ff[`CTL_SLEEP_RUN_DISABLE]);
reg [1:0] com_ff;
reg half_ff;
reg phase_ff;
wire last_com = (com_ff == common_count_sel);
wire com_step = step_tick && (waveform_kind || half_ff);
wire frame_wrap = com_step && last_com;

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    active_ff <= 1'b0;
    com_ff <= 2'h0;
    half_ff <= 1'b0;
    phase_ff <= 1'b0;
    write_allow_ff <= 1'b1;
  end else begin
    active_ff <= nxt_active;
    if (!active_ff) begin
      com_ff <= 2'h0;
      half_ff <= 1'b0;
      phase_ff <= 1'b0;
    end else begin
      if (com_step) begin
        com_ff <= last_com ? 2'h0 : com_ff + 2'h1;
      end
      if (waveform_kind) begin
        if (frame_wrap) begin
          phase_ff <= !phase_ff;
        end
      end else if (step_tick) begin
        half_ff <= !half_ff;
        phase_ff <= !half_ff;
      end
    end
    // pixel writes are held off while the last common of a frame is driven
    write_allow_ff <= !nxt_active || !(last_com && !frame_wrap);
  end
end

////////////////////////////////////////////////////////////////////////////////
// apb decode
wire access = psel && penable;
wire is_ctl = (paddr == `DISPLAY_CONTROL_ADDR);
wire is_phs = (paddr == `DISPLAY_PHASE_ADDR);
wire is_seg = (paddr >= `SEGMENT_PIN_ENABLE_ADDR) && (paddr <= `SEGMENT_PIN_ENABLE_LAST) &&
  (paddr[1:0] == 2'h0);
// byte offset into the pixel bank, then the word index x
wire [7:0] pix_off = paddr - `PIXEL_BANK_ADDR;
wire [5:0] pix_x = pix_off[7:2];
wire [1:0] pix_com = (pix_x >= 6'd18) ? 2'h3 : (pix_x >= 6'd12) ? 2'h2 :
  (pix_x >= 6'd6) ? 2'h1 : 2'h0;
wire [5:0] pix_col6 = pix_x - {1'b0, pix_com, 1'b0} - {2'h0, pix_com, 2'h0} +
  {3'h0, pix_com, 1'b0} - {3'h0, pix_com, 1'b0} - {4'h0, pix_com} - {4'h0, pix_com} +
  {4'h0, pix_com} + {4'h0, pix_com};
wire [2:0] pix_col = pix_col6[2:0];
wire is_pix = (paddr >= `PIXEL_BANK_ADDR) && (paddr <= `PIXEL_BANK_LAST) &&
  (paddr[1:0] == 2'h0) && (pix_col < `PIX_COLUMNS);
wire [4:0] pix_idx = {3'h0, pix_com} * 5'd5 + {2'h0, pix_col};
wire [2:0] seg_idx = paddr[4:2] - 3'h2;
wire mapped = is_ctl || is_phs || is_seg || is_pix;
wire commit = access && pready;
wire wr_commit = commit && pwrite;
wire pix_fault = wr_commit && is_pix && !write_allow_ff;

reg [7:0] rd_val;
always @* begin
  rd_val = 8'h00;
  if (is_ctl) begin
    rd_val = ctl_ff & ~(8'h01 << `CTL_UNUSED);
  end else if (is_phs) begin
    rd_val = phs_ff;
    rd_val[`PHS_ACTIVE] = active_ff;
    rd_val[`PHS_WRITE_ALLOW] = write_allow_ff;
  end else if (is_seg) begin
    rd_val = seg_ff[seg_idx];
  end else if (is_pix) begin
    rd_val = pix_ff[pix_idx];
  end
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    pready <= 1'b0;
    prdata <= 32'h00000000;
    pslverr <= 1'b0;
  end else begin
    pready <= access && !pready;
    pslverr <= access && !pready && !mapped;
    prdata <= (access && !pready) ? {24'h000000, rd_val} : 32'h00000000;
  end
end

////////////////////////////////////////////////////////////////////////////////
// register writes
always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    ctl_ff <= `CTL_RESET;
    phs_ff <= `PHS_RESET;
  end else begin
    if (wr_commit && is_ctl) begin
      ctl_ff[7:6] <= pwdata[7:6];
      ctl_ff[3:0] <= pwdata[3:0];
      ctl_ff[`CTL_UNUSED] <= 1'b0;
    end
    // fault set wins over a software clear in the same cycle
    if (pix_fault) begin
      ctl_ff[`CTL_WRITE_FAULT] <= 1'b1;
    end else if (wr_commit && is_ctl && !pwdata[`CTL_WRITE_FAULT]) begin
      ctl_ff[`CTL_WRITE_FAULT] <= 1'b0;
    end
    if (wr_commit && is_phs) begin
      phs_ff[7:6] <= pwdata[7:6];
      phs_ff[3:0] <= pwdata[3:0];
    end
  end
end

genvar g;
generate
  for (g = 0; g < 5; g = g + 1) begin : g_seg
    always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        seg_ff[g] <= `SEG_RESET;
      end else if (wr_commit && is_seg && seg_idx == g) begin
        seg_ff[g] <= (g == 4) ? {7'h00, pwdata[0]} : pwdata[7:0];
      end
    end
  end
  for (g = 0; g < `PIX_ENTRIES; g = g + 1) begin : g_pix
    always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pix_ff[g] <= `PIX_RESET;
      end else if (wr_commit && is_pix && write_allow_ff && pix_idx == g) begin
        pix_ff[g] <= (g % 5 == 4) ? {7'h00, pwdata[0]} : pwdata[7:0];
      end
    end
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// panel outputs
reg [32:0] row;
reg [32:0] seg_en;
reg [4:0] base;
always @* begin
  base = {3'h0, com_ff} * 5'd5;
  row = {pix_ff[base + 5'd4][0], pix_ff[base + 5'd3], pix_ff[base + 5'd2],
    pix_ff[base + 5'd1], pix_ff[base]};
  seg_en = {seg_ff[4][0], seg_ff[3], seg_ff[2], seg_ff[1], seg_ff[0]};
end

always @(posedge pclk or negedge presetn) begin
  if (!presetn) begin
    backplane_line <= 4'h0;
    frontplane_line <= 33'h000000000;
    glyph_pin_on <= 33'h000000000;
    phase_invert <= 1'b0;
    half_bias_out <= 1'b0;
    driver_active_flag <= 1'b0;
  end else begin
    glyph_pin_on <= seg_en;
    driver_active_flag <= active_ff;
    phase_invert <= active_ff && phase_ff;
    half_bias_out <= phs_ff[`PHS_HALF_BIAS] && (common_count_sel != `COMMON_STATIC) &&
      (common_count_sel != `COMMON_FOUR);
    backplane_line <= active_ff ? (4'h1 << com_ff) : 4'h0;
    frontplane_line <= active_ff ? (row & seg_en) : 33'h000000000;
  end
end

endmodule // lcd_segment_driver_control

// file: rtl/lcd_segment_driver_defines.vh
// register map, field positions, reset values and divider counts of the segment lcd driver
// assumes a 32-bit apb slave with one register per aligned word
`ifndef LCD_SEGMENT_DRIVER_DEFINES_VH
`define LCD_SEGMENT_DRIVER_DEFINES_VH

`define DISPLAY_CONTROL_ADDR 8'h00
`define DISPLAY_PHASE_ADDR 8'h04
`define SEGMENT_PIN_ENABLE_ADDR 8'h08
`define SEGMENT_PIN_ENABLE_LAST 8'h18
`define PIXEL_BANK_ADDR 8'h40
`define PIXEL_BANK_LAST 8'h98

`define CTL_DRIVER_ON 7
`define CTL_SLEEP_RUN_DISABLE 6
`define CTL_WRITE_FAULT 5
`define CTL_UNUSED 4
`define CTL_CLOCK_SRC_HI 3
`define CTL_CLOCK_SRC_LO 2
`define CTL_COMMON_HI 1
`define CTL_COMMON_LO 0

`define PHS_WAVEFORM_KIND 7
`define PHS_HALF_BIAS 6
`define PHS_ACTIVE 5
`define PHS_WRITE_ALLOW 4
`define PHS_DIV_HI 3
`define PHS_DIV_LO 0

`define CTL_RESET 8'h00
`define PHS_RESET 8'h00
`define SEG_RESET 8'h00
`define PIX_RESET 8'h00

`define SRC_SYSTEM 2'h0
`define SRC_TIMER1 2'h1
`define COMMON_STATIC 2'h0
`define COMMON_FOUR 2'h3

`define PIX_BANK_STRIDE 5'h06
`define PIX_COLUMNS 3'h5
`define PIX_ENTRIES 20

`define POSTDIV_SLOW 13'h0020
`define POSTDIV_SYSTEM 8192

`endif

// file: verification/lcd_checker.sv
`timescale 1ns/1ps
// properties on the apb and panel ports of the lcd driver
// assumes a bind into lcd_segment_driver_control
module lcd_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [3:0] backplane_line,
  input wire [32:0] frontplane_line,
  input wire [32:0] glyph_pin_on,
  input wire phase_invert,
  input wire driver_active_flag
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire ctl_wr = acc && pready && pwrite && paddr == 8'h00;
  ////////////////////////////////////////
  one_wait_a: assert property (psel && !penable ##1 acc |=> pready)
    else $error("no answer after one wait");
  idle_ready_a: assert property (!acc |=> !pready)
    else $error("stray ready");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  data_idle_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside ready");
  ctl_unused_a: assert property (pready && !pwrite && paddr == 8'h00 |-> !prdata[4])
    else $error("unused control bit set");
  enable_run_a: assert property (ctl_wr && pwdata[7:6] == 2'h2 |-> ##[1:3] driver_active_flag)
    else $error("driver not started");
  disable_off_a: assert property (ctl_wr && !pwdata[7] |-> ##[1:3] !driver_active_flag)
    else $error("driver not stopped");
  idle_pins_a: assert property (!driver_active_flag && !$past(driver_active_flag) |->
    backplane_line == 4'h0 && frontplane_line == 33'h0 && !phase_invert)
    else $error("panel driven while off");
  one_common_a: assert property (driver_active_flag |-> $onehot0(backplane_line))
    else $error("several commons");
  seg_gate_a: assert property ((frontplane_line & ~glyph_pin_on) == 33'h0)
    else $error("dark on an io pin");
endmodule // lcd_checker
bind lcd_segment_driver_control lcd_checker i_chk (.*);

// file: verification/lcd_panel_model.sv
`timescale 1ns/1ps
// glass panel: keeps the dark pattern seen under each common
// assumes one-hot commons sampled on pclk
module lcd_panel_model (
  input wire pclk,
  input wire [3:0] backplane_line,
  input wire [32:0] frontplane_line,
  input wire phase_invert
);
  logic [32:0] dark_ff [0:3];
  logic [3:0] seen_ff = 4'h0;
  logic [3:0] last_bp_ff = 4'h0;
  logic last_ph_ff = 1'b0;
  int mid_flips = 0;
  always @(posedge pclk) begin
    for (int i = 0; i < 4; i++) begin
      if (backplane_line[i]) dark_ff[i] <= frontplane_line;
    end
    seen_ff <= seen_ff | backplane_line;
    // a phase flip while the common holds marks a type-a waveform
    if (backplane_line == last_bp_ff && phase_invert != last_ph_ff) mid_flips <= mid_flips + 1;
    last_bp_ff <= backplane_line;
    last_ph_ff <= phase_invert;
  end
endmodule // lcd_panel_model

// file: verification/tb_top.sv
`timescale 1ns/1ps
// self-checking bench of the segment lcd driver
// assumes design, panel model and checker compiled first
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sleep_mode = 0;
  logic internal_rc_31k = 0, timer1_osc_clock = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, erv, phase_invert, half_bias_out, driver_active_flag;
  logic [3:0] backplane_line;
  logic [32:0] frontplane_line, glyph_pin_on, ex;
  logic [2:0] div_cnt = 3'h0;
  int failures = 0, n_checks = 0, p, t;
  initial forever #2.5 pclk = ~pclk;
  // timer1 period 8 cycles, rc period 4 cycles
  always @(posedge pclk) begin
    div_cnt <= div_cnt + 3'h1;
    if (div_cnt[1:0] == 2'h3) timer1_osc_clock <= ~timer1_osc_clock;
    if (div_cnt[0]) internal_rc_31k <= ~internal_rc_31k;
  end
  lcd_segment_driver_control #(.POSTDIV_SYSTEM(16)) i_dut (.*);
  lcd_panel_model i_panel (.*);
  ////////////////////////////////////////
  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (failures == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic guard(input int n);
    if (n >= 5000) begin
      failures++;
      print_verdict();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 5000; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    guard(k);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input logic err);
    apb(1'b0, a, 8'h00);
    check({1'b0, rdv}, {25'h0, e});
    check(33'(erv), 33'(err));
  endtask
  // cycles that one common is held, after skipping the partial one
  task automatic step_len(output int n);
    logic [3:0] b;
    int k;
    b = backplane_line;
    for (k = 0; k < 5000 && backplane_line === b; k++) @(posedge pclk);
    guard(k);
    b = backplane_line;
    for (n = 0; n < 5000 && backplane_line === b; n++) @(posedge pclk);
    guard(n);
  endtask
  function automatic logic [7:0] pat(input int y, input int c);
    return 8'(41 + 17 * y + 2 * c);
  endfunction
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rc(8'h00, 8'h00, 1'b0);
    rc(8'h04, 8'h10, 1'b0);
    for (int x = 5; x < 18; x += 6) rc(8'(64 + 4 * x), 8'h00, 1'b1);
    apb(1'b1, 8'h00, 8'h10);
    rc(8'h00, 8'h00, 1'b0);
    for (int k = 0; k < 5; k++) begin
      apb(1'b1, 8'(8 + 4 * k), 8'(129 + k));
      rc(8'(8 + 4 * k), k < 4 ? 8'(129 + k) : 8'h01, 1'b0);
    end
    check(glyph_pin_on, 33'h184838281);
    for (int y = 0; y < 4; y++) begin
      for (int c = 0; c < 5; c++) begin
        apb(1'b1, 8'(64 + 24 * y + 4 * c), pat(y, c));
        rc(8'(64 + 24 * y + 4 * c), c < 4 ? pat(y, c) : pat(y, c) & 8'h01, 1'b0);
      end
    end
    apb(1'b1, 8'h04, 8'h80);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, 8'h00, 8'h00);
      i_panel.seen_ff = 4'h0;
      apb(1'b1, 8'h00, 8'(128 + m));
      for (t = 0; t < 5000 && i_panel.seen_ff !== 4'((2 << m) - 1); t++) @(posedge pclk);
      guard(t);
      if (m > 0) repeat (4) step_len(p);
      check(33'(i_panel.seen_ff), 33'((2 << m) - 1));
    end
    apb(1'b0, 8'h04, 8'h00);
    check(33'(rdv[5]), 33'h1);
    for (int y = 0; y < 4; y++) begin
      for (int c = 0; c < 4; c++) ex[8 * c +: 8] = pat(y, c);
      ex[32] = y % 2 == 0;
      check(i_panel.dark_ff[y], ex & 33'h184838281);
    end
    step_len(p);
    check(33'(p), 33'h10);
    apb(1'b1, 8'h04, 8'h83);
    step_len(p);
    check(33'(p), 33'h40);
    apb(1'b1, 8'h04, 8'h80);
    for (int s = 1; s < 4; s++) begin
      apb(1'b1, 8'h00, 8'(131 + 4 * s));
      repeat (2) step_len(p);
      check(33'(p), s == 1 ? 33'h100 : 33'h80);
    end
    apb(1'b1, 8'h00, 8'h83);
    step_len(p);
    i_panel.mid_flips = 0;
    repeat (6) step_len(p);
    check(33'(i_panel.mid_flips), 33'h0);
    apb(1'b1, 8'h04, 8'h00);
    step_len(p);
    i_panel.mid_flips = 0;
    step_len(p);
    check(33'(i_panel.mid_flips != 0), 33'h1);
    apb(1'b1, 8'h04, 8'h83);
    for (t = 0; t < 8 && backplane_line !== 4'h8; t++) step_len(p);
    check(33'(backplane_line), 33'h8);
    apb(1'b0, 8'h04, 8'h00);
    check(33'(rdv[4]), 33'h0);
    apb(1'b1, 8'h40, 8'h5A);
    rc(8'h00, 8'hA3, 1'b0);
    rc(8'h40, pat(0, 0), 1'b0);
    apb(1'b1, 8'h00, 8'hA3);
    rc(8'h00, 8'hA3, 1'b0);
    apb(1'b1, 8'h00, 8'h82);
    rc(8'h00, 8'h82, 1'b0);
    apb(1'b1, 8'h04, 8'hC0);
    @(posedge pclk);
    check(33'(half_bias_out), 33'h1);
    apb(1'b1, 8'h00, 8'hC2);
    sleep_mode <= 1'b1;
    for (t = 0; t < 5000 && driver_active_flag !== 1'b0; t++) @(posedge pclk);
    guard(t);
    apb(1'b1, 8'h00, 8'h82);
    step_len(p);
    check(33'(driver_active_flag), 33'h1);
    sleep_mode <= 1'b0;
    print_verdict();
  end
endmodule // tb_top
